/* core/sdram_timing_pkg.sv */
/*
 * Shared constants for the SDRAM command interval register block:
 * register byte addresses, field widths, reset codes and counter sizes.
 * Assumes a 32-bit Avalon-MM register port that carries byte addresses.
 */
package sdram_timing_pkg;

  //////////////////////////////////////////////////////////////////////////
  // bus geometry
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int BE_W   = 4;

  //////////////////////////////////////////////////////////////////////////
  // interval indices, one per timing register
  localparam int NUM_INTERVALS     = 6;
  localparam int IDX_WRITE_RECOVERY = 0;
  localparam int IDX_ACT_TO_ACT     = 1;
  localparam int IDX_AUTO_REFRESH   = 2;
  localparam int IDX_EXIT_SELF_REF  = 3;
  localparam int IDX_BANK_TO_BANK   = 4;
  localparam int IDX_MODE_LOAD      = 5;

  //////////////////////////////////////////////////////////////////////////
  // register byte addresses
  localparam logic [31:0] WRITE_RECOVERY_TIME_OFS      = 32'h3108_0044;
  localparam logic [31:0] ACTIVE_TO_ACTIVE_PERIOD_OFS  = 32'h3108_0048;
  localparam logic [31:0] AUTO_REFRESH_PERIOD_OFS      = 32'h3108_004c;
  localparam logic [31:0] EXIT_SELF_REFRESH_TIME_OFS   = 32'h3108_0050;
  localparam logic [31:0] BANK_TO_BANK_LATENCY_OFS     = 32'h3108_0054;
  localparam logic [31:0] MODE_LOAD_TO_ACTIVE_TIME_OFS = 32'h3108_0058;
  localparam logic [31:0] INTERVAL_STATUS_OFS          = 32'h3108_00f0;

  localparam logic [31:0] REG_OFS [NUM_INTERVALS] = '{
    WRITE_RECOVERY_TIME_OFS,
    ACTIVE_TO_ACTIVE_PERIOD_OFS,
    AUTO_REFRESH_PERIOD_OFS,
    EXIT_SELF_REFRESH_TIME_OFS,
    BANK_TO_BANK_LATENCY_OFS,
    MODE_LOAD_TO_ACTIVE_TIME_OFS
  };

  //////////////////////////////////////////////////////////////////////////
  // field widths, all fields sit at bit 0
  localparam int FIELD_LSB = 0;
  localparam int FIELD_W [NUM_INTERVALS] = '{4, 5, 5, 8, 4, 4};
  localparam int FIELD_MAX_W = 8;

  // reset codes: all-ones, the longest interval of each field
  localparam logic [7:0] FIELD_RST [NUM_INTERVALS] = '{
    8'h0f, 8'h1f, 8'h1f, 8'hff, 8'h0f, 8'h0f
  };

  //////////////////////////////////////////////////////////////////////////
  // status register layout
  localparam int STATUS_BUSY_LSB    = 0;
  localparam int STATUS_UNMAPPED_BIT = 8;

  //////////////////////////////////////////////////////////////////////////
  // interval counter: longest interval is 256 cycles
  localparam int CNT_W = 9;

  //////////////////////////////////////////////////////////////////////////
  // avalon response codes
  localparam logic [1:0] RESP_OKAY         = 2'h0;
  localparam logic [1:0] RESP_DECODE_ERROR = 2'h3;

endpackage : sdram_timing_pkg

/* core/interval_timer.sv */
/*
 * Down counter that times one SDRAM command interval.
 * Assumes load_i is a one-cycle pulse from logic on the same clock.
 */
`timescale 1ns/100ps

module interval_timer #(
  parameter int CW = 9
) (
  // clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  // control
  input  wire logic          load_i,
  input  wire logic [CW-1:0] cycles_i,
  // status
  output logic               elapsed_o
);

  logic [CW-1:0] count_r;

  // the count is captured at load, so a later register write only
  // affects the next interval, never the one in flight
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_r <= '0;
    end else if (load_i) begin
      count_r <= cycles_i;
    end else if (count_r != '0) begin
      count_r <= count_r - CW'(1);
    end
  end

  assign elapsed_o = (count_r == '0);

endmodule : interval_timer

/* core/sdram_command_timing_regs.sv */
/*
 * SDRAM command interval registers with an Avalon-MM slave port and
 * one interval timer per setting for the command sequencer.
 * Assumes a single 100 MHz clock shared with the sequencer, whose start
 * pulses come from logic on that clock.
 */
// Overview of operation
// - write recovery: 4-bit code, n+1 cycles
// - active to active: 5-bit code, n+1 cycles
// - auto-refresh period: 5-bit code, n+1 cycles
// - exit self-refresh: 8-bit code, n+1 cycles
// - bank to bank activate: 4-bit, n+1 cycles
// - mode load to active: 4-bit, n+1 cycles
// - every access takes exactly one wait state
// - one shared value for all chip selects
`timescale 1ns/100ps

module sdram_command_timing_regs (
  // clock and reset
  input  wire logic                                  clk_i,
  input  wire logic                                  rst_n_i,
  // avalon-mm register slave
  input  wire logic [sdram_timing_pkg::ADDR_W-1:0]   avs_address_i,
  input  wire logic                                  avs_read_i,
  input  wire logic                                  avs_write_i,
  input  wire logic [sdram_timing_pkg::DATA_W-1:0]   avs_writedata_i,
  input  wire logic [sdram_timing_pkg::BE_W-1:0]     avs_byteenable_i,
  output logic      [sdram_timing_pkg::DATA_W-1:0]   avs_readdata_o,
  output logic      [1:0]                            avs_response_o,
  output logic                                       avs_waitrequest_o,
  // command sequencer side
  input  wire logic [sdram_timing_pkg::NUM_INTERVALS-1:0] interval_start_i,
  output logic      [sdram_timing_pkg::NUM_INTERVALS-1:0] interval_elapsed_o,
  // programmed interval lengths in cycles, shared by all chip selects
  output logic      [sdram_timing_pkg::CNT_W-1:0]    write_recovery_cycles_o,
  output logic      [sdram_timing_pkg::CNT_W-1:0]    act_to_act_cycles_o,
  output logic      [sdram_timing_pkg::CNT_W-1:0]    auto_refresh_cycles_o,
  output logic      [sdram_timing_pkg::CNT_W-1:0]    exit_self_ref_cycles_o,
  output logic      [sdram_timing_pkg::CNT_W-1:0]    bank_to_bank_cycles_o,
  output logic      [sdram_timing_pkg::CNT_W-1:0]    mode_load_cycles_o
);

  localparam int N  = sdram_timing_pkg::NUM_INTERVALS;
  localparam int CW = sdram_timing_pkg::CNT_W;
  localparam int FW = sdram_timing_pkg::FIELD_MAX_W;

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  // mask of the defined bits for a field of the given width
  function automatic logic [FW-1:0] field_mask(input int width);
    logic [FW-1:0] m;
    m = '0;
    for (int b = 0; b < FW; b++) begin
      if (b < width) begin
        m[b] = 1'b1;
      end
    end
    return m;
  endfunction : field_mask

  // all-ones gives 2**width, which is again code plus one
  function automatic logic [CW-1:0] code_to_cycles(input logic [FW-1:0] code,
                                                   input int width);
    logic [CW-1:0] c;
    c = {1'b0, code & field_mask(width)};
    return c + CW'(1);
  endfunction : code_to_cycles

  // one-hot match of an address against the timing registers
  function automatic logic [N-1:0] reg_hit(
    input logic [sdram_timing_pkg::ADDR_W-1:0] addr);
    logic [N-1:0] h;
    h = '0;
    for (int k = 0; k < N; k++) begin
      h[k] = (addr == sdram_timing_pkg::REG_OFS[k]);
    end
    return h;
  endfunction : reg_hit

  ////////////////////////////////////////////////////////////////////////////
  // bus handshake

  logic          req;
  logic          wait_done_r;
  logic          fire;
  logic          wr_fire;
  logic [N-1:0]  hit;
  logic          status_hit;
  logic          mapped;

  assign req        = avs_read_i | avs_write_i;
  assign hit        = reg_hit(avs_address_i);
  assign status_hit =
    (avs_address_i == sdram_timing_pkg::INTERVAL_STATUS_OFS);
  assign mapped     = (|hit) | status_hit;

  // first cycle of a request is the wait state, second completes it
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_done_r <= 1'b0;
    end else begin
      wait_done_r <= req & ~wait_done_r;
    end
  end

  assign avs_waitrequest_o = req & ~wait_done_r;
  assign fire              = req & wait_done_r;
  assign wr_fire           = avs_write_i & wait_done_r;

  ////////////////////////////////////////////////////////////////////////////
  // timing fields, one copy serves every chip select

  logic [FW-1:0] field_r [N];

  generate
    for (genvar i = 0; i < N; i++) begin : g_field
      // only byte lane 0 carries a field; undefined bits are dropped
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          field_r[i] <= sdram_timing_pkg::FIELD_RST[i];
        end else if (wr_fire && hit[i] && avs_byteenable_i[0]) begin
          field_r[i] <= avs_writedata_i[FW-1:0]
                        & field_mask(sdram_timing_pkg::FIELD_W[i]);
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // cycle counts per interval

  logic [CW-1:0] cycles [N];

  generate
    for (genvar i = 0; i < N; i++) begin : g_cycles
      assign cycles[i] = code_to_cycles(field_r[i],
                           sdram_timing_pkg::FIELD_W[i]);
    end
  endgenerate

  assign write_recovery_cycles_o =
    cycles[sdram_timing_pkg::IDX_WRITE_RECOVERY];
  assign act_to_act_cycles_o =
    cycles[sdram_timing_pkg::IDX_ACT_TO_ACT];
  assign auto_refresh_cycles_o =
    cycles[sdram_timing_pkg::IDX_AUTO_REFRESH];
  assign exit_self_ref_cycles_o =
    cycles[sdram_timing_pkg::IDX_EXIT_SELF_REF];
  assign bank_to_bank_cycles_o =
    cycles[sdram_timing_pkg::IDX_BANK_TO_BANK];
  assign mode_load_cycles_o =
    cycles[sdram_timing_pkg::IDX_MODE_LOAD];

  ////////////////////////////////////////////////////////////////////////////
  // interval timers for the command sequencer

  // a new value written mid-interval applies from the next start on,
  // which is harmless as long as software only reprograms when idle
  generate
    for (genvar i = 0; i < N; i++) begin : g_timer
      interval_timer #(
        .CW (CW)
      ) u_timer (
        .clk_i     (clk_i),
        .rst_n_i   (rst_n_i),
        .load_i    (interval_start_i[i]),
        .cycles_i  (cycles[i]),
        .elapsed_o (interval_elapsed_o[i])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // unmapped access flag

  logic unmapped_r;
  logic unmapped_set;
  logic unmapped_clr;

  assign unmapped_set = fire & ~mapped;
  assign unmapped_clr = wr_fire & status_hit & avs_byteenable_i[1]
                        & avs_writedata_i[sdram_timing_pkg::STATUS_UNMAPPED_BIT];

  // a new bad access in the clearing cycle keeps the flag set
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      unmapped_r <= 1'b0;
    end else if (unmapped_set) begin
      unmapped_r <= 1'b1;
    end else if (unmapped_clr) begin
      unmapped_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data and response

  logic [sdram_timing_pkg::DATA_W-1:0] rd_mux;

  always_comb begin
    rd_mux = '0;
    for (int k = 0; k < N; k++) begin
      if (hit[k]) begin
        rd_mux[FW-1:0] = field_r[k];
      end
    end
    if (status_hit) begin
      rd_mux[sdram_timing_pkg::STATUS_BUSY_LSB +: N] = ~interval_elapsed_o;
      rd_mux[sdram_timing_pkg::STATUS_UNMAPPED_BIT]   = unmapped_r;
    end
  end

  // sampled in the wait-state cycle so data is settled at completion
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_readdata_o <= '0;
    end else if (req && !wait_done_r) begin
      avs_readdata_o <= avs_read_i ? rd_mux : '0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_response_o <= sdram_timing_pkg::RESP_OKAY;
    end else if (req && !wait_done_r) begin
      avs_response_o <= mapped ? sdram_timing_pkg::RESP_OKAY
                               : sdram_timing_pkg::RESP_DECODE_ERROR;
    end
  end

endmodule : sdram_command_timing_regs

/* verif/sdram_timing_regs_asserts.sv */
/* checker for the timing register block: bus wait state, field update
   and timer length; bound to every instance of the block below */
`timescale 1ns/100ps
module sdram_timing_regs_asserts (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  // register port
  input wire logic [31:0] avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  // sequencer side
  input wire logic [5:0]  interval_start_i,
  input wire logic [5:0]  interval_elapsed_o,
  input wire logic [8:0]  write_recovery_cycles_o,
  input wire logic [8:0]  act_to_act_cycles_o,
  input wire logic [8:0]  exit_self_ref_cycles_o
);
  logic [8:0] left_r;
  logic       rq;
  logic       wdone;
  assign rq = avs_read_i | avs_write_i;
  assign wdone = avs_write_i & ~avs_waitrequest_o & avs_byteenable_i[0];
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  //////////////////////////////////////////////////////////////////////////
  // timer 0 model: the length is taken at the start edge only
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) left_r <= 9'h000;
    else if (interval_start_i[0]) left_r <= write_recovery_cycles_o;
    else if (left_r != 9'h000) left_r <= left_r - 9'h001;
  end
  a_wait_one: assert property (
    $rose(rq) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("bus wait is not exactly one cycle");
  a_idle_nowait: assert property (
    !rq |-> !avs_waitrequest_o) else $error("wait without request");
  a_wait_short: assert property (
    avs_waitrequest_o |=> !avs_waitrequest_o) else $error("second wait");
  a_wr_update: assert property (
    wdone && avs_address_i == sdram_timing_pkg::WRITE_RECOVERY_TIME_OFS
    |=> write_recovery_cycles_o == {5'h00, $past(avs_writedata_i[3:0])}
        + 9'h001) else $error("write recovery length wrong");
  a_rc_update: assert property (
    wdone && avs_address_i == sdram_timing_pkg::ACTIVE_TO_ACTIVE_PERIOD_OFS
    |=> act_to_act_cycles_o == {4'h0, $past(avs_writedata_i[4:0])}
        + 9'h001) else $error("active period length wrong");
  a_xsr_update: assert property (
    wdone && avs_address_i == sdram_timing_pkg::EXIT_SELF_REFRESH_TIME_OFS
    |=> exit_self_ref_cycles_o == {1'b0, $past(avs_writedata_i[7:0])}
        + 9'h001) else $error("self refresh exit length wrong");
  a_timer_len: assert property (
    interval_elapsed_o[0] == (left_r == 9'h000))
    else $error("write recovery timer length wrong");
  a_start_drop: assert property (
    interval_start_i |=> interval_elapsed_o != 6'h3f)
    else $error("started interval still elapsed");
  a_rd_upper: assert property (
    avs_read_i && !avs_waitrequest_o
    && avs_address_i != sdram_timing_pkg::INTERVAL_STATUS_OFS
    |-> avs_readdata_o[31:8] == 24'h000000) else $error("upper bits set");
  c_write: cover property (wdone);
  c_read: cover property (avs_read_i && !avs_waitrequest_o);
  c_long: cover property (interval_start_i[3]);
endmodule : sdram_timing_regs_asserts

bind sdram_command_timing_regs sdram_timing_regs_asserts u_chk (
  .clk_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
  .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
  .avs_waitrequest_o, .interval_start_i, .interval_elapsed_o,
  .write_recovery_cycles_o, .act_to_act_cycles_o, .exit_self_ref_cycles_o
);

/* verif/interval_seq_model.sv */
/* sequencer stand-in: pulses one interval start, then counts cycles
   until that interval reports elapsed; assumes go_i only when idle */
`timescale 1ns/100ps
module interval_seq_model (
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic [2:0] idx_i,
  input  wire logic [5:0] elapsed_i,
  output logic      [5:0] start_o,
  output logic            busy_o,
  output int              len_o
);
  int k;
  initial begin
    start_o = 6'h00;
    busy_o = 1'b0;
    len_o = 0;
    k = 0;
  end
  always @(posedge clk_i) begin
    start_o <= 6'h00;
    if (go_i) begin
      start_o[idx_i] <= 1'b1;
      busy_o <= 1'b1;
      k <= -1;
    end else if (busy_o) begin
      // the start edge itself is skipped: elapsed may still show high
      if (k >= 0 && elapsed_i[idx_i]) begin
        busy_o <= 1'b0;
        len_o <= k;
      end else k <= k + 1;
    end
  end
endmodule : interval_seq_model

/* verif/sdram_command_timing_regs_tb_top.sv */
/* self-checking bench for the timing register block: bus reads and
   writes, field codes, timer lengths; assumes the bound checker */
`timescale 1ns/100ps
module sdram_command_timing_regs_tb_top;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [31:0] adr = 32'h0, wd = 32'h0, rd, v;
  logic        rdq = 1'b0, wrq = 1'b0, wreq, go = 1'b0, pbusy;
  logic [3:0]  be = 4'hf;
  logic [1:0]  resp;
  logic [5:0]  start, elap;
  logic [8:0]  cyc [6];
  logic [2:0]  idx = 3'h0;
  logic [7:0]  seed = 8'h0a;
  int          len, num_errors = 0, n_checks = 0, m;
  int          fld [6];
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  sdram_command_timing_regs DUT (.clk_i, .rst_n_i, .avs_address_i(adr),
    .avs_read_i(rdq), .avs_write_i(wrq), .avs_writedata_i(wd),
    .avs_byteenable_i(be), .avs_readdata_o(rd), .avs_response_o(resp),
    .avs_waitrequest_o(wreq), .interval_start_i(start),
    .interval_elapsed_o(elap), .write_recovery_cycles_o(cyc[0]),
    .act_to_act_cycles_o(cyc[1]), .auto_refresh_cycles_o(cyc[2]),
    .exit_self_ref_cycles_o(cyc[3]), .bank_to_bank_cycles_o(cyc[4]),
    .mode_load_cycles_o(cyc[5]));
  interval_seq_model u_seq (.clk_i, .go_i(go), .idx_i(idx),
    .elapsed_i(elap), .start_o(start), .busy_o(pbusy), .len_o(len));
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test
  // one request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [31:0] a,
                     input logic [31:0] d, input logic [3:0] b);
    int n;
    n = 0;
    @(posedge clk_i);
    wrq <= w;
    rdq <= !w;
    adr <= a;
    wd <= d;
    be <= b;
    // waitrequest and read data are taken at the same rising edge
    do begin
      @(posedge clk_i);
      n++;
    end while (wreq !== 1'b0 && n < 10);
    v = rd;
    wrq <= 1'b0;
    rdq <= 1'b0;
    check("wait states", n - 1, 1);
  endtask : bus
  task automatic rdchk(input int i);
    bus(1'b0, sdram_timing_pkg::REG_OFS[i], 32'h0, 4'hf);
    check("field", v, fld[i]);
    check("response", resp, sdram_timing_pkg::RESP_OKAY);
    check("cycles", cyc[i], fld[i] + 1);
  endtask : rdchk
  task automatic tmr(input int i);
    int n;
    n = 0;
    @(posedge clk_i);
    go <= 1'b1;
    idx <= i[2:0];
    @(posedge clk_i);
    go <= 1'b0;
    @(negedge clk_i);
    while (pbusy === 1'b1 && n < 400) begin
      n++;
      @(negedge clk_i);
    end
    check("interval", len, fld[i] + 1);
  endtask : tmr
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      fld[i] = sdram_timing_pkg::FIELD_RST[i];
      rdchk(i);
    end
    // codes 0, top-1, all-ones, then random ones
    for (int k = 0; k < 5; k++) begin
      for (int i = 0; i < 6; i++) begin
        m = (1 << sdram_timing_pkg::FIELD_W[i]) - 1;
        seed = lfsr(seed);
        fld[i] = (k == 0) ? 0 : (k == 1) ? m - 1 : (k == 2) ? m : seed & m;
        // timers are idle and upper bits are written as read
        bus(1'b1, sdram_timing_pkg::REG_OFS[i], fld[i], 4'hf);
        rdchk(i);
        tmr(i);
      end
    end
    bus(1'b1, sdram_timing_pkg::REG_OFS[0], 32'h0000_0003, 4'he);
    rdchk(0);
    bus(1'b0, 32'h3108_0040, 32'h0, 4'hf);
    check("unmapped data", v, 32'h0);
    check("unmapped resp", resp, sdram_timing_pkg::RESP_DECODE_ERROR);
    // status: sticky unmapped flag set, every timer idle
    bus(1'b0, sdram_timing_pkg::INTERVAL_STATUS_OFS, 32'h0, 4'hf);
    check("status set", v, 32'h0000_0100);
    bus(1'b1, sdram_timing_pkg::INTERVAL_STATUS_OFS, 32'h0000_0100, 4'hf);
    bus(1'b0, sdram_timing_pkg::INTERVAL_STATUS_OFS, 32'h0, 4'hf);
    check("status clear", v, 32'h0000_0000);
    end_of_test;
  end
  // the whole run needs well under 10000 cycles
  initial begin
    repeat (30000) @(posedge clk_i);
    num_errors++;
    end_of_test;
  end
endmodule : sdram_command_timing_regs_tb_top
